// [shared/pidr_consts.vh]
`ifndef PIDR_CONSTS_VH
`define PIDR_CONSTS_VH

// management addresses of this register slice
`define PIDR_ADDR_IRQ_ENABLE    5'h12
`define PIDR_ADDR_IRQ_FLAGS     5'h13
`define PIDR_ADDR_DG_CONFIG     5'h14
`define PIDR_ADDR_RX_ERR_TALLY  5'h15
`define PIDR_ADDR_IND_ADDRESS   5'h1e
`define PIDR_ADDR_IND_DATA      5'h1f

// reset values
`define PIDR_RST_IRQ_ENABLE     16'h0000
`define PIDR_RST_IRQ_FLAGS      16'h0000
`define PIDR_RST_DG_CONFIG      16'h082c
`define PIDR_RST_RX_ERR_TALLY   16'h0000
`define PIDR_RST_IND_ADDRESS    16'h0000
`define PIDR_RST_DG_EN          1'b1
`define PIDR_RST_DG_ATT         3'h3

// implemented bits of the enable/flag pair and of the config register
`define PIDR_IRQ_MASK           16'hfc63
`define PIDR_DG_MASK            16'h083e

// interrupt source bit positions
`define PIDR_BIT_NEG_FAULT      15
`define PIDR_BIT_RATE_CHANGE    14
`define PIDR_BIT_DUPLEX_CHANGE  13
`define PIDR_BIT_PAGE_RX        12
`define PIDR_BIT_LINK_FAIL      11
`define PIDR_BIT_LINK_UP        10
`define PIDR_BIT_WAKE           6
`define PIDR_BIT_DOWNGRADE      5
`define PIDR_BIT_POLARITY       1
`define PIDR_BIT_JABBER         0

// downgrade config fields
`define PIDR_DG_LATCH_BIT       11
`define PIDR_DG_EN_BIT          5
`define PIDR_DG_ATT_MSB         4
`define PIDR_DG_ATT_LSB         2
`define PIDR_DG_BYPASS_BIT      1
`define PIDR_DG_ATT_EXTRA       4'd2

// management frame
`define PIDR_PREAMBLE_LEN       6'd32
`define PIDR_OP_READ            2'b10
`define PIDR_OP_WRITE           2'b01

// timing
`define PIDR_CLK_PERIOD_NS      32'd4
`define PIDR_STABLE_TIME_MS     32'd2500
`define PIDR_STABLE_CYCLES      (`PIDR_STABLE_TIME_MS * \
                                 (32'd1000000 / `PIDR_CLK_PERIOD_NS))

`endif

// [design/pidr_dgr.v]
`timescale 1ns/1ps
`include "pidr_consts.vh"

module pidr_dgr #(
   parameter [31:0] STABLE_CYCLES = `PIDR_STABLE_CYCLES
) (
   // clock and resets
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       soft_rst_i,
   // configuration
   input  wire       dg_en_i,
   input  wire [2:0] attempts_i,
   input  wire       bypass_i,
   // link state
   input  wire       link_up_i,
   input  wire       attempt_fail_i,
   // results
   output reg        dg_pulse_o,
   output reg        downgraded_o
);

   reg        en_shadow_reg;
   reg [2:0]  att_shadow_reg;
   reg [3:0]  retry_reg;
   reg [31:0] timer_reg;
   reg        link_prev_reg;
   reg        stable_reg;
   wire       limit_hit;
   wire       early_drop;
   wire       fail;
   wire [3:0] limit;

   assign limit      = {1'b0, att_shadow_reg} + `PIDR_DG_ATT_EXTRA;
   // link lost before the stability timer ran out counts as a failure
   assign early_drop = link_prev_reg & ~link_up_i & ~stable_reg;
   assign fail       = attempt_fail_i | early_drop;
   assign limit_hit  = fail & (retry_reg + 4'd1 >= limit);

   // enable and attempt settings take effect only at software reset; bypass acts at once
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_shadow_reg  <= `PIDR_RST_DG_EN;
         att_shadow_reg <= `PIDR_RST_DG_ATT;
      end else if (soft_rst_i) begin
         en_shadow_reg  <= dg_en_i;
         att_shadow_reg <= attempts_i;
      end
   end

   // stability timer, retry counter and downgrade decision
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         retry_reg     <= 4'h0;
         timer_reg     <= 32'h0;
         link_prev_reg <= 1'b0;
         stable_reg    <= 1'b0;
         dg_pulse_o    <= 1'b0;
         downgraded_o  <= 1'b0;
      end else if (soft_rst_i) begin
         retry_reg     <= 4'h0;
         timer_reg     <= 32'h0;
         link_prev_reg <= 1'b0;
         stable_reg    <= 1'b0;
         dg_pulse_o    <= 1'b0;
         downgraded_o  <= 1'b0;
      end else begin
         link_prev_reg <= link_up_i;
         dg_pulse_o    <= 1'b0;
         if (!link_up_i) begin
            timer_reg  <= 32'h0;
            stable_reg <= 1'b0;
         end else if (bypass_i) begin
            stable_reg <= 1'b1;
         end else if (!stable_reg) begin
            if (timer_reg >= STABLE_CYCLES - 32'd1)
               stable_reg <= 1'b1;
            timer_reg <= timer_reg + 32'd1;
         end
         if (link_up_i && stable_reg) begin
            retry_reg <= 4'h0;
         end else if (fail) begin
            if (limit_hit && en_shadow_reg && !downgraded_o) begin
               retry_reg    <= 4'h0;
               dg_pulse_o   <= 1'b1;
               downgraded_o <= 1'b1;
            end else if (retry_reg != 4'hf) begin
               retry_reg <= retry_reg + 4'd1;
            end
         end
      end
   end

endmodule // pidr_dgr

// [design/pidr_regs.v]
`timescale 1ns/1ps
`include "pidr_consts.vh"

module pidr_regs #(
   parameter [31:0] STABLE_CYCLES = `PIDR_STABLE_CYCLES
) (
   // clock and reset
   input  wire        CLK_I,
   input  wire        RESET_N_I,
   input  wire        SOFT_RESET_I,
   // management pins
   input  wire        MDC_I,
   input  wire        MDIO_I,
   output reg         MDIO_O,
   output reg         MDIO_OE_O,
   input  wire [4:0]  PHY_ADDR_I,
   // event sources, one-cycle pulses
   input  wire        NEG_FAULT_EV_I,
   input  wire        RATE_CHANGE_EV_I,
   input  wire        DUPLEX_CHANGE_EV_I,
   input  wire        PAGE_RX_EV_I,
   input  wire        LINK_FAIL_EV_I,
   input  wire        LINK_UP_EV_I,
   input  wire        WAKE_EV_I,
   input  wire        POLARITY_EV_I,
   input  wire        JABBER_EV_I,
   // link state for the downgrade machine
   input  wire        LINK_UP_I,
   input  wire        ATTEMPT_FAIL_I,
   // receive error indication
   input  wire        RX_ER_I,
   // extended register port
   input  wire [15:0] EXT_RDATA_I,
   output reg  [15:0] EXT_ADDR_O,
   output reg  [15:0] EXT_WDATA_O,
   output reg         EXT_WR_O,
   output reg         EXT_RD_O,
   // status outputs
   output reg         IRQ_O,
   output wire        DOWNGRADED_O
);

   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_ST   = 3'd1;
   localparam [2:0] S_OP   = 3'd2;
   localparam [2:0] S_ADDR = 3'd3;
   localparam [2:0] S_TA   = 3'd4;
   localparam [2:0] S_DATA = 3'd5;

   reg  [2:0]  state_reg;
   reg  [5:0]  pre_cnt_reg;
   reg  [3:0]  cnt_reg;
   reg  [15:0] sh_reg;
   reg         op_rd_reg;
   reg         match_reg;
   reg  [4:0]  addr_reg;
   reg         drive_reg;
   reg         hold_reg;
   reg  [15:0] cap_reg;
   reg         mdc_s1, mdc_s2, mdc_s3;
   reg         mdio_s1, mdio_s2;
   reg  [15:0] irq_enable_reg;
   reg  [15:0] irq_flags_reg;
   reg  [15:0] dg_config_reg;
   reg  [15:0] rx_error_tally_reg;
   reg         rx_er_prev_reg;
   reg  [15:0] rd_value;
   reg  [15:0] evt;
   wire        edge_rise;
   wire        bit_in;
   wire        data_last;
   wire        wr_fire;
   wire        rd_end;
   wire [15:0] wr_data;
   wire [15:0] shown;
   wire [15:0] clr_mask;
   wire [3:0]  nxt_idx;
   wire        dg_pulse;

   // mdc passes three flops and mdio two; edge found on the second and third stage
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         mdc_s1  <= 1'b0;
         mdc_s2  <= 1'b0;
         mdc_s3  <= 1'b0;
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         mdc_s1  <= MDC_I;
         mdc_s2  <= mdc_s1;
         mdc_s3  <= mdc_s2;
         mdio_s1 <= MDIO_I;
         mdio_s2 <= mdio_s1;
      end
   end

   assign edge_rise = mdc_s2 & ~mdc_s3;
   assign bit_in    = mdio_s2;
   assign data_last = edge_rise & (state_reg == S_DATA) & (cnt_reg == 4'hf);
   assign wr_fire   = data_last & ~op_rd_reg & match_reg;
   assign rd_end    = data_last & op_rd_reg & match_reg;
   assign wr_data   = {sh_reg[14:0], bit_in};
   assign nxt_idx   = 4'he - cnt_reg;
   assign shown     = hold_reg ? cap_reg : rd_value;

   // read value of the addressed register
   always @* begin
      case (addr_reg)
         `PIDR_ADDR_IRQ_ENABLE:   rd_value = irq_enable_reg;
         `PIDR_ADDR_IRQ_FLAGS:    rd_value = irq_flags_reg;
         `PIDR_ADDR_DG_CONFIG:    rd_value = dg_config_reg;
         `PIDR_ADDR_RX_ERR_TALLY: rd_value = rx_error_tally_reg;
         `PIDR_ADDR_IND_ADDRESS:  rd_value = EXT_ADDR_O;
         `PIDR_ADDR_IND_DATA:     rd_value = EXT_RDATA_I;
         default:                 rd_value = 16'h0000;
      endcase
   end

   // management frame engine, one step per mdc rising edge
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_reg   <= S_IDLE;
         pre_cnt_reg <= 6'h00;
         cnt_reg     <= 4'h0;
         sh_reg      <= 16'h0000;
         op_rd_reg   <= 1'b0;
         match_reg   <= 1'b0;
         addr_reg    <= 5'h00;
         drive_reg   <= 1'b0;
         hold_reg    <= 1'b0;
         cap_reg     <= 16'h0000;
         MDIO_O      <= 1'b1;
         MDIO_OE_O   <= 1'b0;
      end else if (edge_rise) begin
         case (state_reg)
            S_IDLE: begin
               if (bit_in) begin
                  if (pre_cnt_reg != `PIDR_PREAMBLE_LEN)
                     pre_cnt_reg <= pre_cnt_reg + 6'd1;
               end else begin
                  if (pre_cnt_reg == `PIDR_PREAMBLE_LEN)
                     state_reg <= S_ST;
                  pre_cnt_reg <= 6'h00;
               end
            end
            S_ST: begin
               state_reg <= bit_in ? S_OP : S_IDLE;
               cnt_reg   <= 4'h0;
            end
            S_OP: begin
               sh_reg  <= wr_data;
               cnt_reg <= cnt_reg + 4'd1;
               if (cnt_reg == 4'h1) begin
                  cnt_reg   <= 4'h0;
                  op_rd_reg <= ({sh_reg[0], bit_in} == `PIDR_OP_READ);
                  if ({sh_reg[0], bit_in} == `PIDR_OP_READ ||
                      {sh_reg[0], bit_in} == `PIDR_OP_WRITE)
                     state_reg <= S_ADDR;
                  else
                     state_reg <= S_IDLE;
               end
            end
            S_ADDR: begin
               sh_reg  <= wr_data;
               cnt_reg <= cnt_reg + 4'd1;
               if (cnt_reg == 4'h9) begin
                  cnt_reg   <= 4'h0;
                  match_reg <= (sh_reg[8:4] == PHY_ADDR_I);
                  addr_reg  <= {sh_reg[3:0], bit_in};
                  state_reg <= S_TA;
               end
            end
            S_TA: begin
               cnt_reg <= cnt_reg + 4'd1;
               if (cnt_reg == 4'h0) begin
                  // second turnaround bit driven low by the device
                  if (op_rd_reg && match_reg) begin
                     drive_reg <= 1'b1;
                     MDIO_O    <= 1'b0;
                     MDIO_OE_O <= 1'b1;
                     cap_reg   <= rd_value;
                     hold_reg  <= dg_config_reg[`PIDR_DG_LATCH_BIT];
                  end
               end else begin
                  cnt_reg   <= 4'h0;
                  state_reg <= S_DATA;
                  if (drive_reg)
                     MDIO_O <= shown[15];
               end
            end
            S_DATA: begin
               sh_reg  <= wr_data;
               cnt_reg <= cnt_reg + 4'd1;
               if (cnt_reg == 4'hf) begin
                  state_reg   <= S_IDLE;
                  pre_cnt_reg <= 6'h00;
                  drive_reg   <= 1'b0;
                  hold_reg    <= 1'b0;
                  MDIO_O      <= 1'b1;
                  MDIO_OE_O   <= 1'b0;
               end else if (drive_reg) begin
                  MDIO_O <= shown[nxt_idx];
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // event vector placed at the enable positions
   always @* begin
      evt = 16'h0000;
      evt[`PIDR_BIT_NEG_FAULT]     = NEG_FAULT_EV_I;
      evt[`PIDR_BIT_RATE_CHANGE]   = RATE_CHANGE_EV_I;
      evt[`PIDR_BIT_DUPLEX_CHANGE] = DUPLEX_CHANGE_EV_I;
      evt[`PIDR_BIT_PAGE_RX]       = PAGE_RX_EV_I;
      evt[`PIDR_BIT_LINK_FAIL]     = LINK_FAIL_EV_I;
      evt[`PIDR_BIT_LINK_UP]       = LINK_UP_EV_I;
      evt[`PIDR_BIT_WAKE]          = WAKE_EV_I;
      evt[`PIDR_BIT_DOWNGRADE]     = dg_pulse;
      evt[`PIDR_BIT_POLARITY]      = POLARITY_EV_I;
      evt[`PIDR_BIT_JABBER]        = JABBER_EV_I;
   end

   // bits shown at the last data bit are cleared: the latched value, or the live value when unlatched
   assign clr_mask = (rd_end && addr_reg == `PIDR_ADDR_IRQ_FLAGS) ?
                     shown : 16'h0000;

   // writable registers
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_enable_reg <= `PIDR_RST_IRQ_ENABLE;
         dg_config_reg  <= `PIDR_RST_DG_CONFIG;
         EXT_ADDR_O     <= `PIDR_RST_IND_ADDRESS;
      end else if (wr_fire) begin
         case (addr_reg)
            `PIDR_ADDR_IRQ_ENABLE:
               irq_enable_reg <= wr_data & `PIDR_IRQ_MASK;
            `PIDR_ADDR_DG_CONFIG:
               dg_config_reg <= wr_data & `PIDR_DG_MASK;
            `PIDR_ADDR_IND_ADDRESS:
               EXT_ADDR_O <= wr_data;
            default: begin
               EXT_ADDR_O <= EXT_ADDR_O;
            end
         endcase
      end
   end

   // sticky flags, set beats read clear
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         irq_flags_reg <= `PIDR_RST_IRQ_FLAGS;
         IRQ_O         <= 1'b0;
      end else if (SOFT_RESET_I) begin
         irq_flags_reg <= `PIDR_RST_IRQ_FLAGS;
         IRQ_O         <= 1'b0;
      end else begin
         irq_flags_reg <= ((irq_flags_reg & ~clr_mask) | evt) &
                          `PIDR_IRQ_MASK;
         IRQ_O <= |((((irq_flags_reg & ~clr_mask) | evt)) &
                    irq_enable_reg);
      end
   end

   // saturating receive error tally
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rx_error_tally_reg <= `PIDR_RST_RX_ERR_TALLY;
         rx_er_prev_reg     <= 1'b0;
      end else if (SOFT_RESET_I) begin
         rx_error_tally_reg <= `PIDR_RST_RX_ERR_TALLY;
         rx_er_prev_reg     <= 1'b0;
      end else begin
         rx_er_prev_reg <= RX_ER_I;
         if (RX_ER_I && !rx_er_prev_reg &&
             rx_error_tally_reg != 16'hffff)
            rx_error_tally_reg <= rx_error_tally_reg + 16'd1;
      end
   end

   // indirect data port strobes
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         EXT_WDATA_O <= 16'h0000;
         EXT_WR_O    <= 1'b0;
         EXT_RD_O    <= 1'b0;
      end else begin
         EXT_WR_O <= wr_fire && addr_reg == `PIDR_ADDR_IND_DATA;
         EXT_RD_O <= rd_end && addr_reg == `PIDR_ADDR_IND_DATA;
         if (wr_fire && addr_reg == `PIDR_ADDR_IND_DATA)
            EXT_WDATA_O <= wr_data;
      end
   end

   // wirespeed downgrade machine
   pidr_dgr #(
      .STABLE_CYCLES (STABLE_CYCLES)
   ) u_dgr (
      .clk_i          (CLK_I),
      .rst_n_i        (RESET_N_I),
      .soft_rst_i     (SOFT_RESET_I),
      .dg_en_i        (dg_config_reg[`PIDR_DG_EN_BIT]),
      .attempts_i     (dg_config_reg[`PIDR_DG_ATT_MSB:`PIDR_DG_ATT_LSB]),
      .bypass_i       (dg_config_reg[`PIDR_DG_BYPASS_BIT]),
      .link_up_i      (LINK_UP_I),
      .attempt_fail_i (ATTEMPT_FAIL_I),
      .dg_pulse_o     (dg_pulse),
      .downgraded_o   (DOWNGRADED_O)
   );

endmodule // pidr_regs

// [bench/pidr_regs_props.sv]
`timescale 1ns/1ps
// protocol checks on the register slice ports
module pidr_regs_props #(
   parameter [31:0] STABLE_CYCLES = 32'd50
) (
   input wire        CLK_I,
   input wire        RESET_N_I,
   input wire        SOFT_RESET_I,
   input wire        MDC_I,
   input wire        MDIO_OE_O,
   input wire        NEG_FAULT_EV_I,
   input wire        RATE_CHANGE_EV_I,
   input wire        DUPLEX_CHANGE_EV_I,
   input wire        PAGE_RX_EV_I,
   input wire        LINK_FAIL_EV_I,
   input wire        LINK_UP_EV_I,
   input wire        WAKE_EV_I,
   input wire        POLARITY_EV_I,
   input wire        JABBER_EV_I,
   input wire [15:0] EXT_ADDR_O,
   input wire        EXT_WR_O,
   input wire        EXT_RD_O,
   input wire        IRQ_O,
   input wire        DOWNGRADED_O
);
   reg  [11:0] mdc_hist_reg;
   wire        mdc_recent;
   wire        ev_any;

   // recent management clock activity, indirect port and drive changes need it
   always @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I)
         mdc_hist_reg <= 12'h000;
      else
         mdc_hist_reg <= {mdc_hist_reg[10:0], MDC_I};
   end
   assign mdc_recent = |mdc_hist_reg;
   assign ev_any = NEG_FAULT_EV_I | RATE_CHANGE_EV_I | DUPLEX_CHANGE_EV_I |
                   PAGE_RX_EV_I | LINK_FAIL_EV_I | LINK_UP_EV_I |
                   WAKE_EV_I | POLARITY_EV_I | JABBER_EV_I;

   default clocking dc @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);

   // checked one edge on, so the first edge before reset settles is skipped
   rst_quiet_a: assert property (disable iff (1'b0) !RESET_N_I |=>
      !MDIO_OE_O && !IRQ_O && EXT_ADDR_O == 16'h0000 && !EXT_WR_O
      && !DOWNGRADED_O) else $error("outputs not quiet in reset");
   soft_irq_a: assert property (SOFT_RESET_I && !ev_any |=> !IRQ_O)
      else $error("irq survived soft reset");
   soft_dg_a: assert property (SOFT_RESET_I |=> !DOWNGRADED_O)
      else $error("downgrade survived soft reset");
   irq_cause_a: assert property ($rose(IRQ_O) |->
      $past(ev_any) or mdc_recent or ##[0:2] DOWNGRADED_O)
      else $error("irq rose without cause");
   irq_hold_a: assert property ($fell(IRQ_O) |->
      mdc_recent || $past(SOFT_RESET_I)) else $error("irq fell unread");
   wr_pulse_a: assert property ($rose(EXT_WR_O) |-> mdc_recent
      ##1 !EXT_WR_O) else $error("ext write pulse wrong");
   rd_pulse_a: assert property ($rose(EXT_RD_O) |-> mdc_recent
      ##1 !EXT_RD_O) else $error("ext read pulse wrong");
   addr_cause_a: assert property ($changed(EXT_ADDR_O) |->
      mdc_recent) else $error("indirect address changed alone");
   oe_cause_a: assert property ($changed(MDIO_OE_O) |-> mdc_recent)
      else $error("mdio drive changed without mdc");
endmodule // pidr_regs_props

// [bench/pidr_smc_model.sv]
`timescale 1ns/1ps
// station management controller, mdc stands low between frames
module pidr_smc_model (
   input  wire clk_i,
   input  wire mdio_i,
   output reg  mdc_o,
   output reg  host_oe_o,
   output reg  host_d_o
);
   // idle: clock low, data released to the pull-up
   initial begin
      mdc_o = 1'b0;
      host_oe_o = 1'b0;
      host_d_o = 1'b1;
   end

   // one bit: drive after mdc falls, sample at the mdc rise
   task automatic slot(input logic oe, input logic d, output logic smp);
      host_oe_o <= oe;
      host_d_o  <= d;
      repeat (8) @(posedge clk_i);
      smp = mdio_i;
      mdc_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      mdc_o <= 1'b0;
   endtask

   // whole frame, fresh preamble each time, line released at the end
   task automatic frame(input logic [4:0] phy, input logic rd,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rdat);
      logic [63:0] f;
      logic        s;
      integer      i;
      f = {32'hffffffff, 2'b01, (rd ? 2'b10 : 2'b01), phy, ra, 2'b10, wd};
      rdat = 16'h0000;
      @(posedge clk_i);
      for (i = 63; i >= 0; i = i - 1) begin
         slot(!(rd && i < 18), f[i], s);
         if (i < 16)
            rdat[i] = s;
      end
      host_oe_o <= 1'b0;
   endtask
endmodule // pidr_smc_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   localparam [4:0] PHY = 5'h05;
   reg         clk, rst_n, soft_rst, link_up, att_fail, rx_er;
   reg  [8:0]  ev;
   reg  [15:0] ext_rdata;
   wire        mdc, h_oe, h_d, mdio_o, mdio_oe, ext_wr, ext_rd, irq, dgd;
   wire [15:0] ext_addr, ext_wdata;
   logic [15:0] v;
   integer     num_errors, cmp_count, n_wr, n_rd, i;
   int         evb [9] = '{0, 1, 6, 10, 11, 12, 13, 14, 15};
   // resolved management line with pull-up
   wire mdio = mdio_oe ? mdio_o : (h_oe ? h_d : 1'b1);

   pidr_smc_model u_smc (.clk_i(clk), .mdio_i(mdio), .mdc_o(mdc),
      .host_oe_o(h_oe), .host_d_o(h_d));
   pidr_regs #(.STABLE_CYCLES(32'd50)) DUT (.CLK_I(clk), .RESET_N_I(rst_n),
      .SOFT_RESET_I(soft_rst), .MDC_I(mdc), .MDIO_I(mdio), .MDIO_O(mdio_o),
      .MDIO_OE_O(mdio_oe), .PHY_ADDR_I(PHY), .NEG_FAULT_EV_I(ev[8]),
      .RATE_CHANGE_EV_I(ev[7]), .DUPLEX_CHANGE_EV_I(ev[6]),
      .PAGE_RX_EV_I(ev[5]), .LINK_FAIL_EV_I(ev[4]), .LINK_UP_EV_I(ev[3]),
      .WAKE_EV_I(ev[2]), .POLARITY_EV_I(ev[1]), .JABBER_EV_I(ev[0]),
      .LINK_UP_I(link_up), .ATTEMPT_FAIL_I(att_fail), .RX_ER_I(rx_er),
      .EXT_RDATA_I(ext_rdata), .EXT_ADDR_O(ext_addr),
      .EXT_WDATA_O(ext_wdata), .EXT_WR_O(ext_wr), .EXT_RD_O(ext_rd),
      .IRQ_O(irq), .DOWNGRADED_O(dgd));

   // clock and pulse counters
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ext_wr === 1'b1) n_wr = n_wr + 1;
      if (ext_rd === 1'b1) n_rd = n_rd + 1;
   end

   task chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [4:0] ra, input logic [15:0] d);
      u_smc.frame(PHY, 1'b0, ra, d, v);
   endtask
   task rdchk(input string what, input logic [4:0] ra,
              input logic [15:0] exp);
      u_smc.frame(PHY, 1'b1, ra, 16'h0000, v);
      chk(what, exp, v);
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task sr;
      @(posedge clk) soft_rst <= 1'b1;
      @(posedge clk) soft_rst <= 1'b0;
      cyc(3);
   endtask
   task fails(input integer n);
      repeat (n) begin
         @(posedge clk) att_fail <= 1'b1;
         @(posedge clk) att_fail <= 1'b0;
         cyc(3);
      end
      cyc(5);
   endtask
   task lnk(input integer n);
      @(posedge clk) link_up <= 1'b1;
      cyc(n);
      link_up <= 1'b0;
      cyc(6);
   endtask

   task t_reset_vals;
      rdchk("enable", 5'h12, 16'h0000);
      rdchk("flags", 5'h13, 16'h0000);
      rdchk("config", 5'h14, 16'h082c);
      rdchk("tally", 5'h15, 16'h0000);
      rdchk("ind addr", 5'h1e, 16'h0000);
      $display("reset values done");
   endtask
   task t_config;
      wr(5'h12, 16'hffff);
      rdchk("enable ones", 5'h12, 16'hfc63);
      wr(5'h14, 16'hffff);
      rdchk("config ones", 5'h14, 16'h083e);
      wr(5'h14, 16'h0000);
      rdchk("config zero", 5'h14, 16'h0000);
      wr(5'h14, 16'h082c);
      $display("config done");
   endtask
   task t_flags;
      for (i = 0; i < 9; i = i + 1) begin
         wr(5'h12, 16'h0001 << evb[i]);
         @(posedge clk) ev <= 9'h001 << i;
         @(posedge clk) ev <= 9'h000;
         cyc(2);
         chk("irq set", 16'h0001, {15'h0, irq});
         rdchk("flag", 5'h13, 16'h0001 << evb[i]);
         cyc(2);
         chk("irq clr", 16'h0000, {15'h0, irq});
      end
      wr(5'h12, 16'h0000);
      @(posedge clk) ev <= 9'h001;
      @(posedge clk) ev <= 9'h000;
      cyc(2);
      chk("irq masked", 16'h0000, {15'h0, irq});
      rdchk("masked flag", 5'h13, 16'h0001);
      $display("flags done");
   endtask
   task t_downgrade;
      wr(5'h12, 16'h0020);
      sr;
      fails(4);
      chk("dg after 4", 16'h0000, {15'h0, dgd});
      fails(1);
      chk("dg after 5", 16'h0001, {15'h0, dgd});
      chk("dg irq", 16'h0001, {15'h0, irq});
      rdchk("dg flag", 5'h13, 16'h0020);
      sr;
      wr(5'h14, 16'h0820);
      fails(2);
      chk("dg old count", 16'h0000, {15'h0, dgd});
      sr;
      fails(2);
      chk("dg new count", 16'h0001, {15'h0, dgd});
      sr;
      lnk(10);
      lnk(80);
      lnk(10);
      chk("dg stable clears", 16'h0000, {15'h0, dgd});
      lnk(10);
      chk("dg short links", 16'h0001, {15'h0, dgd});
      wr(5'h14, 16'h0822);
      sr;
      lnk(10);
      lnk(10);
      chk("dg bypass", 16'h0000, {15'h0, dgd});
      wr(5'h14, 16'h0800);
      sr;
      fails(4);
      chk("dg disabled", 16'h0000, {15'h0, dgd});
      wr(5'h14, 16'h082c);
      sr;
      $display("downgrade done");
   endtask
   task t_tally;
      repeat (3) begin
         @(posedge clk) rx_er <= 1'b1;
         cyc(3);
         rx_er <= 1'b0;
         cyc(3);
      end
      rdchk("tally 3", 5'h15, 16'h0003);
      sr;
      rdchk("tally cleared", 5'h15, 16'h0000);
      $display("tally done");
   endtask
   task t_indirect;
      wr(5'h1e, 16'ha5c3);
      chk("ext addr", 16'ha5c3, ext_addr);
      rdchk("ind addr rd", 5'h1e, 16'ha5c3);
      n_wr = 0;
      n_rd = 0;
      wr(5'h1f, 16'h1234);
      chk("ext wdata", 16'h1234, ext_wdata);
      ext_rdata <= 16'h5a0f;
      rdchk("ext rdata", 5'h1f, 16'h5a0f);
      cyc(4);
      chk("ext pulses", 16'h0101, {n_wr[7:0], n_rd[7:0]});
      $display("indirect done");
   endtask
   task t_latch;
      for (i = 0; i < 2; i = i + 1) begin
         wr(5'h14, (i == 0) ? 16'h082c : 16'h002c);
         ext_rdata <= 16'hffff;
         fork
            u_smc.frame(PHY, 1'b1, 5'h1f, 16'h0000, v);
            begin
               cyc(900);
               ext_rdata <= 16'h0000;
            end
         join
         if (i == 0)
            chk("latched read", 16'hffff, v);
         else
            chk("live read", 16'h0002, {14'h0, v[15], v[0]});
      end
      wr(5'h14, 16'h082c);
      $display("latch done");
   endtask
   task t_refuse;
      u_smc.frame(PHY ^ 5'h01, 1'b0, 5'h1e, 16'h0000, v);
      chk("foreign write", 16'ha5c3, ext_addr);
      u_smc.frame(PHY ^ 5'h01, 1'b1, 5'h12, 16'h0000, v);
      chk("foreign read", 16'hffff, v);
      rdchk("unmapped", 5'h00, 16'h0000);
      wr(5'h14, 16'h0000);
      @(posedge clk) ev <= 9'h001;
      @(posedge clk) ev <= 9'h000;
      @(posedge clk) rst_n <= 1'b0;
      cyc(6);
      rst_n <= 1'b1;
      cyc(2);
      chk("addr after reset", 16'h0000, ext_addr);
      rdchk("config after reset", 5'h14, 16'h082c);
      rdchk("enable after reset", 5'h12, 16'h0000);
      rdchk("flags after reset", 5'h13, 16'h0000);
      $display("refuse done");
   endtask

   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // main sequence
   initial begin
      num_errors = 0;
      cmp_count = 0;
      n_wr = 0;
      n_rd = 0;
      rst_n = 1'b0;
      soft_rst = 1'b0;
      link_up = 1'b0;
      att_fail = 1'b0;
      rx_er = 1'b0;
      ev = 9'h000;
      ext_rdata = 16'h0000;
      cyc(6);
      rst_n <= 1'b1;
      cyc(4);
      t_reset_vals;
      t_config;
      t_flags;
      t_downgrade;
      t_tally;
      t_indirect;
      t_latch;
      t_refuse;
      stop_test;
   end
   // watchdog against a hung frame
   initial begin
      cyc(95000);
      num_errors = num_errors + 1;
      $display("ERROR watchdog expected done seen timeout");
      stop_test;
   end
endmodule // tb_top

bind pidr_regs pidr_regs_props #(.STABLE_CYCLES(STABLE_CYCLES)) u_props (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .SOFT_RESET_I(SOFT_RESET_I),
   .MDC_I(MDC_I), .MDIO_OE_O(MDIO_OE_O), .NEG_FAULT_EV_I(NEG_FAULT_EV_I),
   .RATE_CHANGE_EV_I(RATE_CHANGE_EV_I),
   .DUPLEX_CHANGE_EV_I(DUPLEX_CHANGE_EV_I), .PAGE_RX_EV_I(PAGE_RX_EV_I),
   .LINK_FAIL_EV_I(LINK_FAIL_EV_I), .LINK_UP_EV_I(LINK_UP_EV_I),
   .WAKE_EV_I(WAKE_EV_I), .POLARITY_EV_I(POLARITY_EV_I),
   .JABBER_EV_I(JABBER_EV_I), .EXT_ADDR_O(EXT_ADDR_O), .EXT_WR_O(EXT_WR_O),
   .EXT_RD_O(EXT_RD_O), .IRQ_O(IRQ_O), .DOWNGRADED_O(DOWNGRADED_O));
